/* File: verilog/ubic_pkg.sv */
// Package with register map, field positions and reset values of the baud and IrDA control block
package ubic_pkg;
	localparam logic [7:0]  BAUD_OFF      = 8'h24;
	localparam logic [7:0]  IRCR_OFF      = 8'h28;
	localparam logic [7:0]  FSEL_OFF      = 8'h30;
	localparam logic [31:0] BAUD_RESET    = 32'h0f000000;
	localparam logic [31:0] IRCR_RESET    = 32'h00000040;
	localparam logic [31:0] FSEL_RESET    = 32'h00000000;
	localparam logic [31:0] BAUD_MASK     = 32'h3f00ffff;
	localparam logic [31:0] IRCR_MASK     = 32'h00000062;
	localparam logic [31:0] FSEL_MASK     = 32'h00000003;
	localparam int          DIV_X_EN_BIT  = 29;
	localparam int          DIV_X_ONE_BIT = 28;
	localparam int          FACTOR_HI     = 27;
	localparam int          FACTOR_LO     = 24;
	localparam int          DIVISOR_HI    = 15;
	localparam int          DIVISOR_LO    = 0;
	localparam int          RX_INV_BIT    = 6;
	localparam int          TX_INV_BIT    = 5;
	localparam int          TX_SEL_BIT    = 1;
	localparam logic [1:0]  FSEL_IRDA     = 2'h2;
	localparam logic [4:0]  OVS_DEFAULT   = 5'h10;
	localparam logic [4:0]  OVS_ONE       = 5'h01;
	localparam logic [16:0] DIVISOR_ADD   = 17'h00002;
endpackage

/* File: verilog/ubic_bus_if.sv */
// Interface carrying decoded register values from the top to the baud generator
`timescale 1ns/1ps
interface ubic_bus_if;
	logic        tick_clear;
	logic [4:0]  ovs_factor;
	logic [16:0] div_count;
	logic        bit_tick;
	logic        sample_tick;
	modport top (output tick_clear, output ovs_factor, output div_count,
		input bit_tick, input sample_tick);
	modport gen (input tick_clear, input ovs_factor, input div_count,
		output bit_tick, output sample_tick);
endinterface

/* File: verilog/ubic_baud_gen.sv */
// Two-stage divider making the oversample and bit-rate enable pulses
`timescale 1ns/1ps
module ubic_baud_gen (
	input  wire logic core_clk,
	input  wire logic resetn,
	ubic_bus_if.gen   bus
);
	typedef struct packed {
		logic [16:0] pre_cnt;
		logic [4:0]  ovs_cnt;
		logic        sample;
		logic        bit_t;
	} ubic_gen_type;

	ubic_gen_type s_q;
	ubic_gen_type s_d;

	always_comb begin
		s_d        = s_q;
		s_d.sample = 1'b0;
		s_d.bit_t  = 1'b0;
		if (bus.tick_clear) begin
			s_d.pre_cnt = 17'h00000;
			s_d.ovs_cnt = 5'h00;
		end else if (s_q.pre_cnt >= bus.div_count - 17'h00001) begin // R01 R06
			// Divide by divisor plus two
			s_d.pre_cnt = 17'h00000;
			s_d.sample  = 1'b1;
			if (s_q.ovs_cnt >= bus.ovs_factor - 5'h01) begin
				s_d.ovs_cnt = 5'h00;
				s_d.bit_t   = 1'b1;
			end else begin
				s_d.ovs_cnt = s_q.ovs_cnt + 5'h01;
			end
		end else begin
			s_d.pre_cnt = s_q.pre_cnt + 17'h00001;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.bit_tick    = s_q.bit_t;
	assign bus.sample_tick = s_q.sample;
endmodule // ubic_baud_gen

/* File: verilog/ubic_top.sv */
// Baud-rate generator and IrDA line control registers with APB slave
//
// Function
// R01: Normal mode: clock over 16 times (divisor+2)
// R02: No extended divider means oversampling sixteen
// R03: Extended, unity clear: factor field plus one
// R04: Extended, unity set: oversampling one
// R05: Factor field at bits 27..24
// R06: Divisor at bits 15..0, plus two
// R07: Software keeps extended divider off in IrDA
// R08: Bit 6 inverts incoming RX line
// R09: Bit 5 inverts outgoing TX line
// R10: Bit 1 selects IrDA transmitter or receiver
// R11: IrDA behaviour only with IrDA function code
// R12: Reserved bits read zero, writes ignored
`timescale 1ns/1ps
module ubic_top (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_line_in,
	input  wire logic        tx_data_in,
	output logic             rx_data_out,
	output logic             tx_line_out,
	output logic             irda_tx_enable,
	output logic             irda_rx_enable,
	output logic             bit_tick,
	output logic             sample_tick
);
	typedef struct packed {
		logic [31:0] baud;
		logic [31:0] ircr;
		logic [31:0] fsel;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic        rx_s1;
		logic        rx_s2;
		logic        rx_out;
		logic        tx_out;
		logic        txe;
		logic        rxe;
		logic        btick;
		logic        stick;
		logic        clr;
		logic [16:0] scnt;
		logic [1:0]  sseen;
		logic [20:0] bcnt;
		logic [1:0]  bseen;
	} ubic_top_type;

	ubic_top_type s_q;
	ubic_top_type s_d;
	ubic_bus_if   gen_bus ();

	ubic_baud_gen u_gen (
		.core_clk (core_clk),
		.resetn   (resetn),
		.bus      (gen_bus)
	);

	logic        access;
	logic        mapped;
	logic        irda_on;
	logic [4:0]  factor;
	logic [16:0] dcount;

	assign access  = psel && penable && !s_q.ready;
	assign mapped  = (paddr == ubic_pkg::BAUD_OFF) || (paddr == ubic_pkg::IRCR_OFF)
		|| (paddr == ubic_pkg::FSEL_OFF);
	assign irda_on = (s_q.fsel[1:0] == ubic_pkg::FSEL_IRDA); // R11

	always_comb begin
		factor = ubic_pkg::OVS_DEFAULT; // R01 R02
		if (s_q.baud[ubic_pkg::DIV_X_EN_BIT]) begin
			if (s_q.baud[ubic_pkg::DIV_X_ONE_BIT]) begin
				factor = ubic_pkg::OVS_ONE; // R04
			end else begin
				factor = {1'b0, s_q.baud[ubic_pkg::FACTOR_HI:ubic_pkg::FACTOR_LO]}
					+ 5'h01; // R03 R05
			end
		end
	end

	assign dcount = {1'b0, s_q.baud[ubic_pkg::DIVISOR_HI:ubic_pkg::DIVISOR_LO]}
		+ ubic_pkg::DIVISOR_ADD; // R06
	assign gen_bus.ovs_factor = factor;
	assign gen_bus.div_count  = dcount;
	assign gen_bus.tick_clear = s_q.clr;

	always_comb begin
		s_d       = s_q;
		s_d.ready = access;
		s_d.err   = access && !mapped;
		s_d.clr   = 1'b0;
		s_d.rdata = 32'h00000000;
		if (access && pwrite) begin
			unique case (paddr)
				ubic_pkg::BAUD_OFF: begin
					s_d.baud = pwdata & ubic_pkg::BAUD_MASK; // R12
					s_d.clr  = 1'b1;
				end
				ubic_pkg::IRCR_OFF: s_d.ircr = pwdata & ubic_pkg::IRCR_MASK; // R12
				ubic_pkg::FSEL_OFF: s_d.fsel = pwdata & ubic_pkg::FSEL_MASK;
				default: ;
			endcase
		end else if (access) begin
			unique case (paddr)
				ubic_pkg::BAUD_OFF: s_d.rdata = s_q.baud;
				ubic_pkg::IRCR_OFF: s_d.rdata = s_q.ircr;
				ubic_pkg::FSEL_OFF: s_d.rdata = s_q.fsel;
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		s_d.rx_s1  = rx_line_in;
		s_d.rx_s2  = s_q.rx_s1;
		// Inversion only acts while the port is in IrDA function
		s_d.rx_out = s_q.rx_s2 ^ (irda_on && s_q.ircr[ubic_pkg::RX_INV_BIT]); // R08 R11
		s_d.tx_out = tx_data_in ^ (irda_on && s_q.ircr[ubic_pkg::TX_INV_BIT]); // R09 R11
		s_d.txe    = irda_on && s_q.ircr[ubic_pkg::TX_SEL_BIT]; // R10 R11
		s_d.rxe    = irda_on && !s_q.ircr[ubic_pkg::TX_SEL_BIT]; // R10 R11
		s_d.btick  = gen_bus.bit_tick;
		s_d.stick  = gen_bus.sample_tick;
		// Tick spacing is trusted only from the second tick after a restart
		s_d.scnt   = s_q.stick ? 17'h00001 : s_q.scnt + 17'h00001;
		s_d.bcnt   = s_q.btick ? 21'h000001 : s_q.bcnt + 21'h000001;
		if (s_q.clr) begin
			s_d.sseen = 2'h0;
			s_d.bseen = 2'h0;
		end else begin
			if (s_q.stick && s_q.sseen != 2'h2) begin
				s_d.sseen = s_q.sseen + 2'h1;
			end
			if (s_q.btick && s_q.bseen != 2'h2) begin
				s_d.bseen = s_q.bseen + 2'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_q       <= '0;
			s_q.baud  <= ubic_pkg::BAUD_RESET;
			s_q.ircr  <= ubic_pkg::IRCR_RESET;
			s_q.fsel  <= ubic_pkg::FSEL_RESET;
			s_q.rx_s1 <= 1'b1;
			s_q.rx_s2 <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata         = s_q.rdata;
	assign pready         = s_q.ready;
	assign pslverr        = s_q.err;
	assign rx_data_out    = s_q.rx_out;
	assign tx_line_out    = s_q.tx_out;
	assign irda_tx_enable = s_q.txe;
	assign irda_rx_enable = s_q.rxe;
	assign bit_tick       = s_q.btick;
	assign sample_tick    = s_q.stick;

	logic [4:0]  m_rule;
	logic [16:0] div_rule;
	logic [20:0] bit_rule;
	// Oversampling from the mode table, kept apart from the datapath decode
	always_comb begin
		unique case ({s_q.baud[ubic_pkg::DIV_X_EN_BIT], s_q.baud[ubic_pkg::DIV_X_ONE_BIT]})
			2'h2: m_rule = {1'b0, s_q.baud[ubic_pkg::FACTOR_HI:ubic_pkg::FACTOR_LO]} + 5'h01;
			2'h3: m_rule = ubic_pkg::OVS_ONE;
			default: m_rule = ubic_pkg::OVS_DEFAULT;
		endcase
	end
	assign div_rule = {1'b0, s_q.baud[ubic_pkg::DIVISOR_HI:ubic_pkg::DIVISOR_LO]} + ubic_pkg::DIVISOR_ADD;
	assign bit_rule = {16'h0000, m_rule} * {4'h0, div_rule};

	sequence seq_wr_baud;
		psel && penable && pwrite && !pready && paddr == ubic_pkg::BAUD_OFF;
	endsequence

	sequence seq_wr_ircr;
		psel && penable && pwrite && !pready && paddr == ubic_pkg::IRCR_OFF;
	endsequence

	sequence seq_wr_fsel;
		psel && penable && pwrite && !pready && paddr == ubic_pkg::FSEL_OFF;
	endsequence

	sequence seq_wr_unmapped;
		psel && penable && pwrite && !pready && !mapped;
	endsequence

	sequence seq_rd_baud;
		psel && penable && !pwrite && !pready && paddr == ubic_pkg::BAUD_OFF;
	endsequence

	sequence seq_rd_ircr;
		psel && penable && !pwrite && !pready && paddr == ubic_pkg::IRCR_OFF;
	endsequence

	a_apb_ready_one: assert property (@(posedge core_clk) disable iff (!resetn)
		(psel && penable && !pready) |=> pready)
		else $error("pready not given one cycle after access");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn) // R12
		pready && !pwrite && paddr == ubic_pkg::BAUD_OFF |-> (prdata & ~ubic_pkg::BAUD_MASK) == 0)
		else $error("reserved baud bits read nonzero");
	a_baud_stored: assert property (@(posedge core_clk) disable iff (!resetn) // R05 R06
		seq_wr_baud |=> s_q.baud == ($past(pwdata) & ubic_pkg::BAUD_MASK))
		else $error("baud register not stored");
	a_mode_sixteen: assert property (@(posedge core_clk) disable iff (!resetn) // R01 R02
		!s_q.baud[ubic_pkg::DIV_X_EN_BIT] |-> factor == 5'h10)
		else $error("default oversampling not sixteen");
	a_mode_factor: assert property (@(posedge core_clk) disable iff (!resetn) // R03
		s_q.baud[29:28] == 2'h2 |-> factor == {1'b0, s_q.baud[27:24]} + 5'h01)
		else $error("factor mode wrong");
	a_mode_unity: assert property (@(posedge core_clk) disable iff (!resetn) // R04
		s_q.baud[29:28] == 2'h3 |-> factor == 5'h01)
		else $error("unity mode wrong");
	a_rx_invert: assert property (@(posedge core_clk) disable iff (!resetn) // R08
		$stable(s_q.ircr) && $stable(s_q.fsel) |=> rx_data_out == ($past(s_q.rx_s2)
		^ $past(irda_on && s_q.ircr[ubic_pkg::RX_INV_BIT])))
		else $error("rx inversion wrong");
	a_tx_invert: assert property (@(posedge core_clk) disable iff (!resetn) // R09
		$stable(s_q.ircr) && $stable(s_q.fsel) |=> tx_line_out == ($past(tx_data_in)
		^ $past(irda_on && s_q.ircr[ubic_pkg::TX_INV_BIT])))
		else $error("tx inversion wrong");
	a_dir_select: assert property (@(posedge core_clk) disable iff (!resetn) // R10 R11
		$stable(s_q.ircr) && $stable(s_q.fsel)
		|=> irda_tx_enable == $past(irda_on && s_q.ircr[ubic_pkg::TX_SEL_BIT])
		&& !(irda_tx_enable && irda_rx_enable))
		else $error("direction select wrong");

	// Register bus
	a_ready_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
		pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_err_ready: assert property (@(posedge core_clk) disable iff (!resetn)
		pslverr |-> pready)
		else $error("pslverr outside a completion");
	a_err_unmapped: assert property (@(posedge core_clk) disable iff (!resetn) // R12
		pready |-> pslverr == !$past(mapped))
		else $error("pslverr does not match address decode");
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (!resetn)
		!pready |-> prdata == 32'h00000000)
		else $error("read data not zero between accesses");
	a_write_silent: assert property (@(posedge core_clk) disable iff (!resetn)
		pready && $past(pwrite) |-> prdata == 32'h00000000)
		else $error("read data not zero after a write");
	a_read_baud: assert property (@(posedge core_clk) disable iff (!resetn) // R05 R06
		seq_rd_baud |=> prdata == $past(s_q.baud))
		else $error("baud register read wrong");
	a_read_ircr: assert property (@(posedge core_clk) disable iff (!resetn) // R08 R09 R10
		seq_rd_ircr |=> prdata == $past(s_q.ircr))
		else $error("line control register read wrong");
	a_ircr_stored: assert property (@(posedge core_clk) disable iff (!resetn) // R08 R09 R10 R12
		seq_wr_ircr |=> s_q.ircr == ($past(pwdata) & ubic_pkg::IRCR_MASK))
		else $error("line control register not stored");
	a_fsel_stored: assert property (@(posedge core_clk) disable iff (!resetn) // R11 R12
		seq_wr_fsel |=> s_q.fsel == ($past(pwdata) & ubic_pkg::FSEL_MASK))
		else $error("function select not stored");
	a_unmapped_ignored: assert property (@(posedge core_clk) disable iff (!resetn) // R12
		seq_wr_unmapped |=> $stable(s_q.baud) && $stable(s_q.ircr) && $stable(s_q.fsel))
		else $error("unmapped write changed a register");
	a_ircr_reserved: assert property (@(posedge core_clk) disable iff (!resetn) // R12
		pready && !$past(pwrite) && $past(paddr) == ubic_pkg::IRCR_OFF
		|-> (prdata & ~ubic_pkg::IRCR_MASK) == 32'h00000000)
		else $error("reserved line control bits read nonzero");
	a_fsel_reserved: assert property (@(posedge core_clk) disable iff (!resetn) // R12
		pready && !$past(pwrite) && $past(paddr) == ubic_pkg::FSEL_OFF
		|-> (prdata & ~ubic_pkg::FSEL_MASK) == 32'h00000000)
		else $error("reserved function select bits read nonzero");

	// Line control
	a_enable_excl: assert property (@(posedge core_clk) disable iff (!resetn) // R10
		!(irda_tx_enable && irda_rx_enable))
		else $error("transmitter and receiver enabled together");
	a_uart_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // R11
		!irda_on |=> !irda_tx_enable && !irda_rx_enable)
		else $error("direction enable outside infrared function");
	a_tx_pass: assert property (@(posedge core_clk) disable iff (!resetn) // R09 R11
		!irda_on |=> tx_line_out == $past(tx_data_in))
		else $error("tx line altered outside infrared function");
	a_rx_pass: assert property (@(posedge core_clk) disable iff (!resetn) // R08 R11
		!irda_on |=> rx_data_out == $past(s_q.rx_s2))
		else $error("rx line altered outside infrared function");

	// Divider
	a_restart_clear: assert property (@(posedge core_clk) disable iff (!resetn) // R06
		seq_wr_baud |=> gen_bus.tick_clear)
		else $error("baud write did not restart the divider");
	a_clear_quiet: assert property (@(posedge core_clk) disable iff (!resetn) // R06
		gen_bus.tick_clear |-> ##2 (!sample_tick && !bit_tick))
		else $error("stale tick after divider restart");
	a_bit_in_sample: assert property (@(posedge core_clk) disable iff (!resetn) // R01 R03 R04
		bit_tick |-> sample_tick)
		else $error("bit tick without sample tick");
	a_sample_period: assert property (@(posedge core_clk) disable iff (!resetn) // R06
		sample_tick && s_q.sseen == 2'h2 && !s_q.clr |-> s_q.scnt == div_rule)
		else $error("sample tick spacing wrong");
	a_bit_period: assert property (@(posedge core_clk) disable iff (!resetn) // R01 R02 R03 R04 R05
		bit_tick && s_q.bseen == 2'h2 && !s_q.clr |-> s_q.bcnt == bit_rule)
		else $error("bit tick spacing wrong");
endmodule // ubic_top

/* File: sim/ubic_line_model.sv */
// Serial line partner that drives the receive pin from a level set by the bench
`timescale 1ns/1ps
module ubic_line_model (
	input  wire logic core_clk,
	input  wire logic level,
	output logic      rx_line
);
	// Launched on the same edge by a nonblocking update, so the design samples the level from before that edge
	always_ff @(posedge core_clk) begin
		rx_line <= level;
	end
endmodule // ubic_line_model

/* File: sim/uart_baud_irda_control_tb_top.sv */
// Register, divider and line tests of the baud and IrDA control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module uart_baud_irda_control_tb_top;
	logic        core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, rx_line_in, tx_data_in = 0, lvl = 0;
	logic        rx_data_out, tx_line_out, irda_tx_enable, irda_rx_enable;
	logic        bit_tick, sample_tick;
	int          err_total = 0, cmp_count = 0, cyc = 0, n;
	int          per_b[3] = '{48, 90, 5};
	int          per_s[3] = '{3, 10, 5};
	logic [31:0] cfg[3] = '{32'h00000001, 32'h28000008, 32'h30000003};
	always #25 core_clk = ~core_clk;
	ubic_top i_ubic_top (.core_clk(core_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line_in(rx_line_in),
		.tx_data_in(tx_data_in), .rx_data_out(rx_data_out), .tx_line_out(tx_line_out),
		.irda_tx_enable(irda_tx_enable), .irda_rx_enable(irda_rx_enable),
		.bit_tick(bit_tick), .sample_tick(sample_tick));
	ubic_line_model i_ubic_line_model (.core_clk(core_clk), .level(lvl),
		.rx_line(rx_line_in));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Cycles between two later ticks, skipping the one after a restart
	task automatic per(input bit s, output int c);
		repeat (2) begin
			@(posedge core_clk);
			while ((s ? sample_tick : bit_tick) !== 1'b1) @(posedge core_clk);
		end
		c = 0;
		do begin
			@(posedge core_clk);
			c++;
		end while ((s ? sample_tick : bit_tick) !== 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1;
		apb(0, ubic_pkg::BAUD_OFF, 0);
		`CHK("baud reset", ubic_pkg::BAUD_RESET, rd)
		apb(0, ubic_pkg::IRCR_OFF, 0);
		`CHK("ircr reset", ubic_pkg::IRCR_RESET, rd)
		apb(0, ubic_pkg::FSEL_OFF, 0);
		`CHK("fsel reset", ubic_pkg::FSEL_RESET, rd)
		apb(1, ubic_pkg::BAUD_OFF, 32'hffffffff);
		apb(0, ubic_pkg::BAUD_OFF, 0);
		`CHK("baud mask", ubic_pkg::BAUD_MASK, rd)
		apb(1, ubic_pkg::IRCR_OFF, 32'hffffffff);
		apb(0, ubic_pkg::IRCR_OFF, 0);
		`CHK("ircr mask", ubic_pkg::IRCR_MASK, rd)
		`CHK("mapped err", 1'b0, er)
		apb(0, 8'h3c, 0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h00000000, rd)
		for (int i = 0; i < 3; i++) begin
			apb(1, ubic_pkg::BAUD_OFF, cfg[i]);
			per(1, n);
			`CHK("sample period", per_s[i], n)
			per(0, n);
			`CHK("bit period", per_b[i], n)
		end
		// Software keeps the extended divider off while in IrDA mode
		apb(1, ubic_pkg::BAUD_OFF, 32'h00000001);
		apb(1, ubic_pkg::FSEL_OFF, 32'h00000002);
		apb(1, ubic_pkg::IRCR_OFF, 32'h00000062);
		lvl <= 1;
		tx_data_in <= 1;
		repeat (6) @(posedge core_clk);
		`CHK("tx inv", 1'b0, tx_line_out)
		`CHK("rx inv", 1'b0, rx_data_out)
		`CHK("tx en", 1'b1, irda_tx_enable)
		`CHK("rx en", 1'b0, irda_rx_enable)
		apb(1, ubic_pkg::IRCR_OFF, 32'h00000000);
		repeat (6) @(posedge core_clk);
		`CHK("tx plain", 1'b1, tx_line_out)
		`CHK("rx plain", 1'b1, rx_data_out)
		`CHK("rx en on", 1'b1, irda_rx_enable)
		apb(1, ubic_pkg::IRCR_OFF, 32'h00000062);
		apb(1, ubic_pkg::FSEL_OFF, 32'h00000000);
		repeat (6) @(posedge core_clk);
		`CHK("uart tx", 1'b1, tx_line_out)
		`CHK("uart rx", 1'b1, rx_data_out)
		`CHK("uart en", 2'h0, {irda_tx_enable, irda_rx_enable})
		summarize();
	end
endmodule // uart_baud_irda_control_tb_top
